// file: bench/sca_engine_model.sv
// engine model that answers issued commands
`timescale 1ns/10ps
`include "sca_map.svh"
module sca_engine_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_slow,
    input  wire logic       i_cmd_valid,
    input  wire logic [7:0] i_cmd_code,
    input  wire logic [7:0] i_cmd_param,
    output logic            o_mac_load,
    output logic      [4:0] o_mac_idx,
    output logic      [7:0] o_mac_byte,
    output logic            o_prot_set,
    output logic      [3:0] o_prot_page,
    output logic      [7:0] o_prot_value
);
    logic [7:0] code;
    logic [7:0] par;
    initial begin
        {o_mac_load, o_mac_idx, o_mac_byte} = '0;
        {o_prot_set, o_prot_page, o_prot_value} = '0;
        forever begin
            @(posedge i_clk_sys);
            if (i_cmd_valid === 1'b1) begin
                code = i_cmd_code;
                par  = i_cmd_param;
                repeat (i_slow ? 5 : 1) @(negedge i_clk_sys);
                if (code == `SCA_OP_SET_PROT || code == `SCA_OP_AUTH_PROT) begin
                    o_prot_set   = 1'b1;
                    o_prot_page  = par[3:0];
                    o_prot_value = par ^ 8'h5A;
                    @(negedge i_clk_sys);
                    o_prot_set   = 1'b0;
                    o_prot_value = ~o_prot_value;
                end
                if (code == `SCA_OP_PAGE_SIG) begin
                    for (int i = 0; i < 32; i++) begin
                        o_mac_load = 1'b1;
                        o_mac_idx  = i[4:0];
                        o_mac_byte = par ^ i[7:0];
                        @(negedge i_clk_sys);
                    end
                    o_mac_load = 1'b0;
                    o_mac_byte = ~o_mac_byte;
                end
            end
        end
    end
endmodule : sca_engine_model

// file: bench/test_sca_regs.sv
// self-checking bench for the command and status front end
`timescale 1ns/10ps
`include "sca_map.svh"
module test_sca_regs;
    import sca_pkg::*;
    logic       i_clk_sys = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_ptr_ld = 1'b0, i_rd = 1'b0;
    logic       slow = 1'b0, o_rd_valid, o_cmd_valid, i_mac_load, i_prot_set;
    logic [7:0] i_addr = '0, i_wdata = '0, o_rdata, o_cmd_code, o_cmd_param;
    logic [7:0] o_host_mac_byte, i_mac_byte, i_prot_value, c, p;
    logic [4:0] i_host_mac_idx = '0, i_mac_idx;
    logic [3:0] i_prot_page;
    logic [7:0] prot_m[16] = '{default: 8'h00};
    logic [7:0] mac_m[32];
    logic [7:0] codes[7] = '{`SCA_OP_WRITE_MEM, `SCA_OP_READ_MEM, `SCA_OP_SET_PROT,
        `SCA_OP_INST_SECRET, `SCA_OP_PAGE_SIG, `SCA_OP_AUTH_WRITE, `SCA_OP_AUTH_PROT};
    int         fails = 0, checked = 0, seed = 32'h7b74_07b0;
    always #25 i_clk_sys = ~i_clk_sys;
    sca_regs dut (.i_clk_sys, .i_rst, .i_wr, .i_addr, .i_wdata, .i_ptr_ld, .i_rd, .o_rdata,
        .o_rd_valid, .o_cmd_valid, .o_cmd_code, .o_cmd_param, .i_mac_load, .i_mac_idx,
        .i_mac_byte, .o_host_mac_byte, .i_host_mac_idx, .i_prot_set, .i_prot_page,
        .i_prot_value);
    sca_engine_model engine (.i_clk_sys, .i_slow(slow), .i_cmd_valid(o_cmd_valid),
        .i_cmd_code(o_cmd_code), .i_cmd_param(o_cmd_param), .o_mac_load(i_mac_load),
        .o_mac_idx(i_mac_idx), .o_mac_byte(i_mac_byte), .o_prot_set(i_prot_set),
        .o_prot_page(i_prot_page), .o_prot_value(i_prot_value));
    // ----
    // bus, check and finish tasks
    // ----
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_addr  = a;
        i_wdata = d;
        i_wr    = 1'b1;
        @(negedge i_clk_sys);
        i_wr    = 1'b0;
    endtask : wr
    task ptr(input logic [7:0] a);
        @(negedge i_clk_sys);
        i_addr   = a;
        i_ptr_ld = 1'b1;
        @(negedge i_clk_sys);
        i_ptr_ld = 1'b0;
    endtask : ptr
    task rd(input string n, input logic [7:0] e);
        int k;
        @(negedge i_clk_sys);
        i_rd = 1'b1;
        @(negedge i_clk_sys);
        i_rd = 1'b0;
        k = 0;
        while (o_rd_valid !== 1'b1 && k < 4) begin
            @(negedge i_clk_sys);
            k++;
        end
        if (k == 4) begin
            $display("Error %s_valid expected 1 seen 0", n);
            fails++;
            complete_run();
        end
        chk(n, e, o_rdata);
    endtask : rd
    task cmd(input logic [7:0] cc, input logic [7:0] pp);
        wr(`SCA_ADDR_CMD, cc);
        if (cc != `SCA_OP_INST_SECRET) wr(`SCA_ADDR_CMD, pp);
        chk("cmd_valid", 8'h01, {7'h00, o_cmd_valid});
        chk("cmd_code", cc, o_cmd_code);
        chk("cmd_param", (cc == `SCA_OP_INST_SECRET) ? 8'h00 : pp, o_cmd_param);
    endtask : cmd
    task complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst = 1'b0;
        for (int i = 0; i < 16; i++) wr(`SCA_ADDR_PROT_LO + i[7:0], 8'($random(seed)));
        ptr(`SCA_ADDR_PROT_LO);
        for (int i = 0; i < 16; i++) rd("status", prot_m[i]);
        ptr(`SCA_ADDR_CMD);
        rd("cmd_read", 8'h00);
        $display("test status and write-only done");
        wr(`SCA_ADDR_CMD, 8'h12);
        chk("unknown_valid", 8'h00, {7'h00, o_cmd_valid});
        wr(`SCA_ADDR_CMD, 8'h34);
        chk("unknown_valid", 8'h00, {7'h00, o_cmd_valid});
        $display("test unknown codes done");
        for (int r = 0; r < 14; r++) begin
            c    = codes[r % 7];
            p    = 8'($random(seed));
            slow = 1'($random(seed));
            cmd(c, p);
            repeat (40) @(negedge i_clk_sys);
            if (c == `SCA_OP_SET_PROT || c == `SCA_OP_AUTH_PROT) begin
                prot_m[p[3:0]] = p ^ 8'h5A;
                rd("status", prot_m[p[3:0]]);
            end else if (c == `SCA_OP_PAGE_SIG) begin
                for (int i = 0; i < 32; i++) rd("mac", p ^ i[7:0]);
            end else begin
                rd("ptr_zero", 8'h00);
            end
        end
        $display("test commands done");
        cmd(`SCA_OP_READ_MEM, 8'h00);
        for (int i = 0; i < 32; i++) begin
            mac_m[i] = 8'($random(seed));
            wr(`SCA_ADDR_MAC, mac_m[i]);
        end
        for (int i = 0; i < 32; i++) begin
            @(negedge i_clk_sys);
            i_host_mac_idx = i[4:0];
            @(negedge i_clk_sys);
            chk("host_mac", mac_m[i], o_host_mac_byte);
        end
        $display("test host mac done");
        ptr(`SCA_ADDR_PROT_LO);
        for (int i = 0; i < 16; i++) rd("status", prot_m[i]);
        $display("test status sweep done");
        complete_run();
    end
endmodule : test_sca_regs

// file: rtl/sca_cmd_decode.sv
// one- and two-byte function command decoder
`timescale 1ns/10ps
`include "sca_map.svh"
module sca_cmd_decode
    import sca_pkg::*;
(
    input  wire logic   i_clk_sys,
    input  wire logic   i_rst,
    sca_cmd_if.dec      cmd
);
    sca_dec_t s_q;
    sca_dec_t s_d;

    function automatic logic known_op(input logic [7:0] c);
        known_op = (c == `SCA_OP_WRITE_MEM) || (c == `SCA_OP_READ_MEM) ||
                   (c == `SCA_OP_SET_PROT) || (c == `SCA_OP_INST_SECRET) ||
                   (c == `SCA_OP_PAGE_SIG) || (c == `SCA_OP_AUTH_WRITE) ||
                   (c == `SCA_OP_AUTH_PROT);
    endfunction : known_op

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.cmd_valid = 1'b0;
        if (cmd.wr_stb) begin
            if (!s_q.phase) begin
                if (known_op(cmd.wdata)) begin
                    if (cmd.wdata == `SCA_OP_INST_SECRET) begin
                        s_d.cmd_valid = 1'b1;
                        s_d.cmd_code  = cmd.wdata;
                        s_d.cmd_param = `SCA_BYTE_ZERO;
                    end else begin
                        s_d.phase = 1'b1;
                        s_d.code  = cmd.wdata;
                    end
                end
            end else begin
                s_d.phase     = 1'b0;
                s_d.cmd_valid = 1'b1;
                s_d.cmd_code  = s_q.code;
                s_d.cmd_param = cmd.wdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd.cmd_valid = s_q.cmd_valid;
    assign cmd.cmd_code  = s_q.cmd_code;
    assign cmd.cmd_param = s_q.cmd_param;

    a_param_before_issue: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_q.cmd_valid && s_q.cmd_code != `SCA_OP_INST_SECRET |-> $past(s_q.phase))
        else $error("command issued without parameter byte");
    a_known_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_q.cmd_valid |-> known_op(s_q.cmd_code))
        else $error("unknown command issued");
    c_two_byte: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        s_q.phase ##1 s_q.cmd_valid);
endmodule : sca_cmd_decode

// file: rtl/sca_cmd_if.sv
// carrier between register front end and command decoder
`timescale 1ns/10ps
interface sca_cmd_if;
    logic       wr_stb;
    logic [7:0] wdata;
    logic       cmd_valid;
    logic [7:0] cmd_code;
    logic [7:0] cmd_param;
    modport dec (input wr_stb, input wdata, output cmd_valid, output cmd_code,
                 output cmd_param);
    modport regs (output wr_stb, output wdata, input cmd_valid, input cmd_code,
                  input cmd_param);
endinterface : sca_cmd_if

// file: rtl/sca_map.svh
// register map, command codes and read pointer targets
`ifndef SCA_MAP_SVH
`define SCA_MAP_SVH
`define SCA_ADDR_CMD       8'h40
`define SCA_ADDR_MAC       8'h41
`define SCA_ADDR_PROT_LO   8'h50
`define SCA_ADDR_PROT_HI   8'h5F
`define SCA_ADDR_ZERO      8'h00
`define SCA_BYTE_ZERO      8'h00
`define SCA_PROT_RST       8'h00
`define SCA_MAC_BYTES      32
`define SCA_PAGES          16
`define SCA_OP_WRITE_MEM   8'h96
`define SCA_OP_READ_MEM    8'h69
`define SCA_OP_SET_PROT    8'hC3
`define SCA_OP_INST_SECRET 8'hAA
`define SCA_OP_PAGE_SIG    8'hA5
`define SCA_OP_AUTH_WRITE  8'h99
`define SCA_OP_AUTH_PROT   8'hCC
`define SCA_PTR_SCRATCH    8'h00
`define SCA_PTR_MAC        8'h41
`define SCA_PTR_PROT       8'h50
`endif

// file: rtl/sca_pkg.sv
// types shared by the command front end
`include "sca_map.svh"
package sca_pkg;
    typedef struct packed {
        logic       phase;
        logic [7:0] code;
        logic       cmd_valid;
        logic [7:0] cmd_code;
        logic [7:0] cmd_param;
    } sca_dec_t;

    typedef struct packed {
        logic [`SCA_PAGES-1:0][7:0]     prot;
        logic [`SCA_MAC_BYTES-1:0][7:0] mac;
        logic [4:0]                     mac_idx;
        logic [7:0]                     ptr;
        logic                           prot_armed;
        logic [7:0]                     rdata;
        logic                           rd_valid;
        logic [7:0]                     host_mac;
    } sca_regs_t;
endpackage : sca_pkg

// file: rtl/sca_regs.sv
// command, MAC port and page protection status register front end
`timescale 1ns/10ps
`include "sca_map.svh"
// Function
// - commands are a code byte then a parameter byte (install secret is the code byte alone), both decoded first.
// - command code selects operation and sets next read pointer.
// - one address serves MAC writes by host and computed MAC reads.
// - sixteen protection status registers from 50h, page 0 first.
// - protections change only through set protection commands, then shown.
// - page signature uses secret, page, scratchpad and unique serial number.
// - command register is write-only; reads there return zero.
// - status registers readable anytime; direct writes ignored.
module sca_regs
    import sca_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_ptr_ld,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic            o_rd_valid,
    output logic            o_cmd_valid,
    output logic      [7:0] o_cmd_code,
    output logic      [7:0] o_cmd_param,
    input  wire logic       i_mac_load,
    input  wire logic [4:0] i_mac_idx,
    input  wire logic [7:0] i_mac_byte,
    output logic      [7:0] o_host_mac_byte,
    input  wire logic [4:0] i_host_mac_idx,
    input  wire logic       i_prot_set,
    input  wire logic [3:0] i_prot_page,
    input  wire logic [7:0] i_prot_value
);
    sca_regs_t s_q;
    sca_regs_t s_d;
    sca_cmd_if cmd_bus ();
    logic      in_prot;
    logic      set_op;

    sca_cmd_decode u_dec (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .cmd       (cmd_bus.dec)
    );

    // ----------------------------------------------------------------
    // command path
    // ----------------------------------------------------------------
    // command register writes feed decoder
    assign cmd_bus.wr_stb = i_wr && (i_addr == `SCA_ADDR_CMD);
    assign cmd_bus.wdata  = i_wdata;
    assign o_cmd_valid    = cmd_bus.cmd_valid;
    assign o_cmd_code     = cmd_bus.cmd_code;
    assign o_cmd_param    = cmd_bus.cmd_param;
    assign set_op = (cmd_bus.cmd_code == `SCA_OP_SET_PROT) ||
                    (cmd_bus.cmd_code == `SCA_OP_AUTH_PROT);
    assign in_prot = (s_q.ptr >= `SCA_ADDR_PROT_LO) && (s_q.ptr <= `SCA_ADDR_PROT_HI);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        if (i_prot_set && s_q.prot_armed) begin
            s_d.prot[i_prot_page] = i_prot_value;
            s_d.prot_armed        = 1'b0;
        end
        // host MAC stored for engine check
        if (i_wr && (i_addr == `SCA_ADDR_MAC)) begin
            s_d.mac[s_q.mac_idx] = i_wdata;
            s_d.mac_idx          = s_q.mac_idx + 5'h1;
        end
        if (i_mac_load) begin
            s_d.mac[i_mac_idx] = i_mac_byte;
        end
        if (i_rd) begin
            s_d.rd_valid = 1'b1;
            if (s_q.ptr == `SCA_ADDR_CMD) begin
                s_d.rdata = `SCA_BYTE_ZERO;
            end else if (s_q.ptr == `SCA_ADDR_MAC) begin
                s_d.rdata   = s_q.mac[s_q.mac_idx];
                s_d.mac_idx = s_q.mac_idx + 5'h1;
            end else if (in_prot) begin
                s_d.rdata = s_q.prot[s_q.ptr[3:0]];
                s_d.ptr   = s_q.ptr + 8'h01;
            end else begin
                s_d.rdata = `SCA_BYTE_ZERO;
                s_d.ptr   = s_q.ptr + 8'h01;
            end
        end
        if (i_ptr_ld) begin
            s_d.ptr = i_addr;
        end
        if (cmd_bus.cmd_valid) begin
            s_d.mac_idx    = '0;
            s_d.prot_armed = set_op;
            unique case (cmd_bus.cmd_code)
                `SCA_OP_PAGE_SIG: s_d.ptr = `SCA_PTR_MAC;
                `SCA_OP_SET_PROT,
                `SCA_OP_AUTH_PROT: s_d.ptr = `SCA_PTR_PROT + {4'h0, cmd_bus.cmd_param[3:0]};
                default:          s_d.ptr = `SCA_PTR_SCRATCH;
            endcase
        end
        // host MAC byte held in a register
        s_d.host_mac = s_q.mac[i_host_mac_idx];
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata         = s_q.rdata;
    assign o_rd_valid      = s_q.rd_valid;
    assign o_host_mac_byte = s_q.host_mac;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_cmd_ptr_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cmd_bus.cmd_valid && cmd_bus.cmd_code == `SCA_OP_PAGE_SIG && !i_ptr_ld
        |=> s_q.ptr == `SCA_PTR_MAC)
        else $error("page signature did not aim pointer at MAC port");
    a_cmd_reads_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rd && s_q.ptr == `SCA_ADDR_CMD |=> o_rd_valid && o_rdata == `SCA_BYTE_ZERO)
        else $error("command register read returned data");
    a_prot_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rd && in_prot |=> o_rdata == $past(s_q.prot[s_q.ptr[3:0]]))
        else $error("status read returned wrong page");
    a_prot_only_cmd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(i_prot_set && s_q.prot_armed) |=> $stable(s_q.prot))
        else $error("protection changed without set command");
    a_prot_no_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_wr && i_addr >= `SCA_ADDR_PROT_LO && i_addr <= `SCA_ADDR_PROT_HI && !i_prot_set
        |=> $stable(s_q.prot))
        else $error("direct write altered protection");
    a_mac_write_idx: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_wr && i_addr == `SCA_ADDR_MAC && !cmd_bus.cmd_valid && !i_mac_load
        |=> s_q.mac[$past(s_q.mac_idx)] == $past(i_wdata))
        else $error("MAC byte not stored at port index");
    a_mac_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_mac_load |=> s_q.mac[$past(i_mac_idx)] == $past(i_mac_byte))
        else $error("computed MAC byte lost");
    a_rd_one_cycle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_rd_valid |=> !o_rd_valid || $past(i_rd))
        else $error("read valid held without read");

    // ----------------------------------------------------------------
    // pointer, arming and port checks
    // ----------------------------------------------------------------
    a_rd_valid_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rd
        |=> o_rd_valid)
        else $error("read not answered next cycle");
    a_rdata_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_rd
        |=> $stable(o_rdata))
        else $error("read data changed without read");
    a_mac_rd_port: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rd && s_q.ptr == `SCA_ADDR_MAC && !i_ptr_ld && !cmd_bus.cmd_valid
        |=> s_q.ptr == `SCA_ADDR_MAC && s_q.mac_idx == $past(s_q.mac_idx) + 5'h1)
        else $error("MAC port read moved pointer or kept index");
    a_prot_ptr_inc: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rd && in_prot && !i_ptr_ld && !cmd_bus.cmd_valid
        |=> s_q.ptr == $past(s_q.ptr) + 8'h01)
        else $error("status read did not advance pointer");
    a_set_ptr_page: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cmd_bus.cmd_valid && set_op
        |=> s_q.ptr - `SCA_PTR_PROT == {4'h0, $past(cmd_bus.cmd_param[3:0])})
        else $error("set protection did not aim pointer at page status");
    a_other_ptr_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cmd_bus.cmd_valid && !set_op && cmd_bus.cmd_code != `SCA_OP_PAGE_SIG
        |=> s_q.ptr == `SCA_PTR_SCRATCH)
        else $error("other command did not aim pointer at scratch");
    a_armed_by_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cmd_bus.cmd_valid
        |=> s_q.prot_armed == $past(set_op))
        else $error("arming does not follow command kind");
    a_armed_consumed: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_prot_set && s_q.prot_armed && !cmd_bus.cmd_valid
        |=> !s_q.prot_armed)
        else $error("arming not consumed by protection update");
    a_prot_applied: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_prot_set && s_q.prot_armed
        |=> s_q.prot[$past(i_prot_page)] == $past(i_prot_value))
        else $error("armed protection update lost");
    a_mac_idx_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cmd_bus.cmd_valid
        |=> s_q.mac_idx == '0)
        else $error("MAC index not cleared by command");
    a_host_mac_out: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_mac_load
        |=> o_host_mac_byte == $past(s_q.mac[i_host_mac_idx]))
        else $error("host MAC byte not presented");
    a_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rd && s_q.ptr < `SCA_ADDR_CMD
        |=> o_rdata == `SCA_BYTE_ZERO)
        else $error("scratch area read returned data");
    c_host_mac: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        i_wr && i_addr == `SCA_ADDR_MAC);
    c_sig_read: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        cmd_bus.cmd_valid && cmd_bus.cmd_code == `SCA_OP_PAGE_SIG ##[1:20] i_rd);
    c_prot_set: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        i_prot_set && s_q.prot_armed);
    c_prot_read: cover property (@(posedge i_clk_sys) disable iff (i_rst) i_rd && in_prot);
endmodule : sca_regs
